// ### rtl/bvs_pkg.sv
package bvs_pkg;
    // register map, word indices on the plain register port
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_NORMAL     = 4'h0;   // normal_voltage_setpoint
    localparam logic [3:0]  ADDR_STANDBY    = 4'h1;   // standby_setpoint_code
    localparam logic [3:0]  ADDR_SLEEP      = 4'h2;   // sleep_setpoint_code
    localparam logic [3:0]  ADDR_STATUS     = 4'h3;   // applied code and voltage
    localparam logic [3:0]  ADDR_CONFIG     = 4'h4;   // service unlock control

    // code layout
    localparam int          CODE_W          = 7;
    localparam int          STEP_W          = 6;
    localparam int          RANGE_BIT       = 6;
    localparam int          DATA_W          = 32;
    localparam int          MV_W            = 12;
    localparam int          STATUS_MV_LSB   = 8;
    localparam int          CONFIG_UNLOCK   = 0;

    // reset values of the writable step fields
    localparam logic [5:0]  STEP_RESET      = 6'h00;

    // decode figures in millivolts
    localparam logic [11:0] LOW_BASE_MV     = 12'h190;  // 400 mV
    localparam logic [11:0] LOW_STEP_MV     = 12'h019;  // 25 mV
    localparam logic [11:0] HIGH_BASE_MV    = 12'h320;  // 800 mV
    localparam logic [11:0] HIGH_STEP_MV    = 12'h032;  // 50 mV
    localparam logic [11:0] LOW_MAX_MV      = 12'h7B7;  // 1975 mV
    localparam logic [11:0] HIGH_MAX_MV     = 12'hCE4;  // 3300 mV

    // operating states
    typedef enum logic [1:0]
    {
        MODE_NORMAL  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SLEEP   = 2'b10
    } bvs_mode_type;
endpackage : bvs_pkg

// ### rtl/bvs_setpoint.sv
// Overview of operation
// (R1) Range bit, bit 6 of normal code, is read-only to software normally.
// (R2) Range bit comes from default configuration, or OTP value when programmed.
// (R3) Range 0: 400 mV plus 25 mV per count, at most 1975 mV.
// (R4) Range 1: 800 mV plus 50 mV per count, at most 3300 mV.
// (R5) Separate six-bit codes per state; the current state's code is applied.
// (R6) Initial range bit is copied into standby and sleep codes' bit 6.
// (R7) Software uses high range for 2.0-3.3 V, low range for 0.4-1.975 V.
// (R8) Software never programs codes decoding to 0.6 V or below.
// (R9) Writes to the range bit are ignored normally; low six bits still update.
//
// Implementation choices: the address-and-strobe port and the register offsets.
module bvs_setpoint
(
    input  wire logic                          sys_clk,         // 100 MHz clock
    input  wire logic                          srst,            // sync reset, high
    input  wire logic                          default_range,   // strap default range
    input  wire logic                          otp_programmed,  // OTP holds a range
    input  wire logic                          otp_range,       // OTP range value
    input  wire logic [1:0]                    mode_sel,        // operating state
    input  wire logic [bvs_pkg::ADDR_W-1:0]    reg_addr,        // register index
    input  wire logic [bvs_pkg::DATA_W-1:0]    reg_wdata,       // write data
    input  wire logic                          reg_wr,          // write strobe
    input  wire logic                          reg_rd,          // read strobe
    output logic      [bvs_pkg::DATA_W-1:0]    reg_rdata,       // read data, next cycle
    output logic      [bvs_pkg::CODE_W-1:0]    applied_code,    // code in use
    output logic      [bvs_pkg::MV_W-1:0]      target_mv,       // decoded target, mV
    output logic                               code_over_max    // code beyond range top
);
    // pin-side inputs pass two flops before use; stage one feeds stage two only
    localparam int     SYNC_W     = 5;   // strap, OTP value, OTP valid, two mode bits
    localparam int     SYNC_STRAP = 4;
    localparam int     SYNC_OTPV  = 3;
    localparam int     SYNC_OTPOK = 2;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync1_nxt;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync2_nxt;
    logic [1:0]        mode_r;
    logic [1:0]        mode_nxt;

    // range and per-state step fields
    // step entries: 0 normal, 1 standby, 2 sleep
    logic       range_r;
    logic       range_nxt;
    logic       range_valid_r;
    logic       range_valid_nxt;
    logic       unlock_r;
    logic       unlock_nxt;
    logic [5:0] step_r [3];
    logic [5:0] step_nxt [3];

    // outputs
    logic [bvs_pkg::DATA_W-1:0] rdata_nxt;
    logic [bvs_pkg::CODE_W-1:0] code_nxt;
    logic [bvs_pkg::MV_W-1:0]   mv_nxt;
    logic                       over_nxt;
    logic [bvs_pkg::MV_W-1:0]   mv_calc;
    logic [5:0]                 cur_step;

    // two-stage synchroniser next values; only stage two is read by logic
    // mode takes a third register so code and voltage move on one edge
    always_comb
    begin
        sync1_nxt = {default_range, otp_range, otp_programmed, mode_sel};
        sync2_nxt = sync1_r;
        mode_nxt  = sync2_r[1:0];
    end

    // the two stages run through reset so the range latch at release sees
    // settled configuration inputs; clearing them would force range 0 whatever the strap and OTP
    always_ff @(posedge sys_clk)
    begin
        sync1_r <= sync1_nxt;
        sync2_r <= sync2_nxt;
        if (srst)
        begin
            mode_r <= 2'(bvs_pkg::MODE_NORMAL);
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // register writes; range is latched once after reset from stable inputs
    always_comb
    begin
        range_nxt       = range_r;
        range_valid_nxt = range_valid_r;
        unlock_nxt      = unlock_r;
        for (int i = 0; i < 3; i++)
        begin
            step_nxt[i] = step_r[i];
        end
        if (!range_valid_r)
        begin
            // default strap unless OTP has been programmed; latched once so a later
            // change of the configuration inputs cannot move a running regulator
            range_nxt       = sync2_r[SYNC_OTPOK] ? sync2_r[SYNC_OTPV]
                                                  : sync2_r[SYNC_STRAP];     // see (R2)
            range_valid_nxt = 1'b1;
        end
        if (reg_wr)
        begin
            unique case (reg_addr)
                bvs_pkg::ADDR_NORMAL:
                begin
                    step_nxt[0] = reg_wdata[bvs_pkg::STEP_W-1:0];        // see (R9)
                    if (unlock_r)
                    begin
                        // only in service mode may the range bit move; it is shared,
                        // so standby and sleep follow, hence software keeps it locked
                        range_nxt = reg_wdata[bvs_pkg::RANGE_BIT];       // see (R1)
                    end
                end
                bvs_pkg::ADDR_STANDBY:
                begin
                    step_nxt[1] = reg_wdata[bvs_pkg::STEP_W-1:0];        // see (R5)
                end
                bvs_pkg::ADDR_SLEEP:
                begin
                    step_nxt[2] = reg_wdata[bvs_pkg::STEP_W-1:0];        // see (R5)
                end
                bvs_pkg::ADDR_CONFIG:
                begin
                    unlock_nxt = reg_wdata[bvs_pkg::CONFIG_UNLOCK];
                end
                default:
                begin
                end
            endcase
        end
    end

    // range, unlock and step registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            range_r       <= 1'b0;
            range_valid_r <= 1'b0;
            unlock_r      <= 1'b0;
            for (int i = 0; i < 3; i++)
            begin
                step_r[i] <= bvs_pkg::STEP_RESET;
            end
        end
        else
        begin
            range_r       <= range_nxt;
            range_valid_r <= range_valid_nxt;
            unlock_r      <= unlock_nxt;
            for (int i = 0; i < 3; i++)
            begin
                step_r[i] <= step_nxt[i];
            end
        end
    end

    // select the current state's code, decode to millivolts, answer reads
    always_comb
    begin
        // the unused mode code falls back to the normal code
        unique case (mode_r)
            2'(bvs_pkg::MODE_STANDBY): cur_step = step_r[1];             // see (R5)
            2'(bvs_pkg::MODE_SLEEP):   cur_step = step_r[2];             // see (R5)
            default:                   cur_step = step_r[0];
        endcase
        // one shared range bit keeps all three states in one range
        code_nxt = {range_r, cur_step};                                  // see (R6)
        if (range_r)
        begin
            mv_calc  = bvs_pkg::HIGH_BASE_MV
                     + 12'(cur_step) * bvs_pkg::HIGH_STEP_MV;            // see (R4)
            over_nxt = mv_calc > bvs_pkg::HIGH_MAX_MV;                   // see (R4)
        end
        else
        begin
            mv_calc  = bvs_pkg::LOW_BASE_MV
                     + 12'(cur_step) * bvs_pkg::LOW_STEP_MV;             // see (R3)
            over_nxt = mv_calc > bvs_pkg::LOW_MAX_MV;                    // see (R3)
        end
        // reserved codes clamp to the range top rather than overshoot
        mv_nxt = over_nxt ? (range_r ? bvs_pkg::HIGH_MAX_MV : bvs_pkg::LOW_MAX_MV)
                          : mv_calc;
        // read data answer only the cycle after the strobe; idle cycles show zero
        rdata_nxt = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                bvs_pkg::ADDR_NORMAL:  rdata_nxt[bvs_pkg::CODE_W-1:0] = {range_r, step_r[0]};
                bvs_pkg::ADDR_STANDBY: rdata_nxt[bvs_pkg::CODE_W-1:0] = {range_r, step_r[1]};
                bvs_pkg::ADDR_SLEEP:   rdata_nxt[bvs_pkg::CODE_W-1:0] = {range_r, step_r[2]};
                bvs_pkg::ADDR_STATUS:
                begin
                    rdata_nxt[bvs_pkg::CODE_W-1:0] = applied_code;
                    rdata_nxt[bvs_pkg::STATUS_MV_LSB +: bvs_pkg::MV_W] = target_mv;
                end
                bvs_pkg::ADDR_CONFIG:  rdata_nxt[bvs_pkg::CONFIG_UNLOCK] = unlock_r;
                default:               rdata_nxt = '0;
            endcase
        end
    end

    // every output leaves a flop, so the power stage never sees a glitching code
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            reg_rdata     <= '0;
            applied_code  <= '0;
            target_mv     <= '0;
            code_over_max <= 1'b0;
        end
        else
        begin
            reg_rdata     <= rdata_nxt;
            applied_code  <= code_nxt;
            target_mv     <= mv_nxt;
            code_over_max <= over_nxt;
        end
    end
endmodule : bvs_setpoint

// ### test/bvs_setpoint_props.sv
module bvs_setpoint_props
(
    input wire logic        sys_clk,        // clock
    input wire logic        srst,           // reset
    input wire logic        default_range,  // strap
    input wire logic        otp_programmed, // otp valid
    input wire logic        otp_range,      // otp value
    input wire logic [3:0]  reg_addr,       // index
    input wire logic        reg_rd,         // read
    input wire logic [31:0] reg_rdata,      // read data
    input wire logic [6:0]  applied_code,   // code used
    input wire logic [11:0] target_mv,      // decoded mV
    input wire logic        code_over_max   // reserved flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    // outputs settle two edges after release, so each check but AST_STATUS_CODE waits three
    AST_RANGE_FIXED: assert property (
        !$past(srst, 3) |-> $stable(applied_code[6]))
        else $error("range bit moved");
    AST_RANGE_SRC: assert property (
        !$past(srst, 3) |-> applied_code[6] == (otp_programmed ? otp_range : default_range))
        else $error("range source wrong");
    AST_LOW_DECODE: assert property (
        !applied_code[6] && !$past(srst, 3) |->
        target_mv == 12'h190 + 12'h019 * 12'(applied_code[5:0]) && !code_over_max)
        else $error("low range decode wrong");
    AST_HIGH_DECODE: assert property (
        applied_code[6] && applied_code[5:0] <= 6'h32 && !$past(srst, 3) |->
        target_mv == 12'h320 + 12'h032 * 12'(applied_code[5:0]) && !code_over_max)
        else $error("high range decode wrong");
    AST_COPY_RANGE: assert property (
        reg_rd && (reg_addr == 4'h1 || reg_addr == 4'h2) && !$past(srst, 3) |=>
        reg_rdata[6] == applied_code[6])
        else $error("copied range differs");
    AST_NORMAL_RO: assert property (
        reg_rd && reg_addr == 4'h0 && !$past(srst, 3) |=>
        reg_rdata[6] == applied_code[6] && reg_rdata[31:7] == 25'h0)
        else $error("normal code readback wrong");
    AST_STATUS_CODE: assert property (
        reg_rd && reg_addr == 4'h3 ##1 $stable(applied_code) |-> reg_rdata[6:0] == applied_code)
        else $error("status code differs");
endmodule : bvs_setpoint_props

bind bvs_setpoint bvs_setpoint_props bvs_setpoint_props_inst
(
    .sys_clk, .srst, .default_range, .otp_programmed, .otp_range, .reg_addr, .reg_rd,
    .reg_rdata, .applied_code, .target_mv, .code_over_max
);

// ### test/bvs_setpoint_tb_top.sv
module bvs_setpoint_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'h0;
    logic        srst = 1'h1;
    logic [2:0]  cfg = 3'h0;  // strap, otp valid, otp value
    logic [1:0]  mode = 2'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic [31:0] rdata;
    logic [6:0]  code;
    logic [11:0] mv;
    logic        over;
    int          err_total = 0;
    int          n_checks = 0;

    bvs_setpoint bvs_setpoint_inst
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .default_range(cfg[2]),
        .otp_programmed(cfg[1]),
        .otp_range(cfg[0]),
        .mode_sel(mode),
        .reg_addr(addr),
        .reg_wdata(wdata),
        .reg_wr(wr),
        .reg_rd(rd),
        .reg_rdata(rdata),
        .applied_code(code),
        .target_mv(mv),
        .code_over_max(over)
    );

    // free-running 100 MHz clock
    initial
        forever #5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // an idle edge after each access keeps a strobe from being set twice at once
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge sys_clk);
        wr <= 1'h0;
        @(posedge sys_clk);
    endtask : wr_reg

    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'h1;
        @(posedge sys_clk);
        rd <= 1'h0;
        @(negedge sys_clk);
        cmp(rdata, e);
        @(posedge sys_clk);
    endtask : rd_reg

    // expected {flag, mV, code}
    function automatic logic [31:0] exp_out(input logic r, input logic [5:0] s);
        logic [11:0] m;
        m = r ? 12'h320 + 12'h032 * 12'(s) : 12'h190 + 12'h019 * 12'(s);
        return {12'h0, 1'h0, m, r, s};
    endfunction : exp_out

    // each pass resets with another strap and otp mix, then walks all modes
    initial
    begin
        logic [2:0]  cfgs [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
        logic [5:0]  st [3] = '{6'h32, 6'h28, 6'h18};  // advised targets only
        logic        r;
        logic [31:0] e;
        foreach (cfgs[i])
        begin
            srst <= 1'h1;
            cfg <= cfgs[i];
            mode <= 2'h0;
            repeat (10) @(posedge sys_clk);
            srst <= 1'h0;
            r = cfgs[i][1] ? cfgs[i][0] : cfgs[i][2];
            repeat (3) @(posedge sys_clk);
            rd_reg(4'h0, {25'h0, r, 6'h00});
            for (int m = 0; m < 3; m++)
                wr_reg(4'(m), {25'h0, ~r, st[m]});
            for (int m = 0; m < 3; m++)
                rd_reg(4'(m), {25'h0, r, st[m]});
            for (int m = 0; m < 4; m++)
            begin
                mode <= 2'(m);
                e = exp_out(r, st[m % 3]);
                // outputs move four edges after the mode pins; look mid-cycle once settled
                repeat (5) @(posedge sys_clk);
                @(negedge sys_clk);
                cmp({12'h0, over, mv, code}, e);
                @(posedge sys_clk);
                rd_reg(4'h3, {12'h0, e[18:7], 1'h0, e[6:0]});
            end
            rd_reg(4'h4, 32'h0);  // service unlock is clear after reset
            wr_reg(4'h4, 32'h1);
            rd_reg(4'h4, 32'h1);  // service unlock reads back
            rd_reg(4'h7, 32'h0);  // unmapped index reads zero
        end
        give_verdict();
    end

    // the tests need about 300 cycles
    initial
    begin
        repeat (1000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end
endmodule : bvs_setpoint_tb_top
